// ===== core/csram_core.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module csram_core #(
  parameter bit DEEP = 1'b0,
  parameter int AW = DEEP ? csram_pkg::ADDR_W_DEEP : csram_pkg::ADDR_W_WIDE,
  parameter int DW = DEEP ? csram_pkg::DATA_W_DEEP : csram_pkg::DATA_W_WIDE
) (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire csram_pkg::csr_ctrl_s ctrl_in, // Strobe, select, write, gate, kill pins
  input wire logic [AW-1:0] addr_in, // Address pins
  input wire logic [DW-1:0] data_in, // Data input pins
  output logic [DW-1:0] data_out, // Output data register
  output logic data_oe_n, // Output buffer enable, low drives
  output logic access_done_flag, // Access complete status
  output csram_pkg::csr_phases_s phases, // Address latch phases
  output logic [1:0] addr_bit5_rails, // Row bit 5 true and complement
  output logic [csram_pkg::ROW_COUNT-1:0] row_select // One-hot row drivers
);
  import csram_pkg::*;

  localparam int COL_W = AW - ROW_BITS;
  localparam int COLS = 1 << COL_W;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] DEC_N = CNT_W'(DECODE_CYCLES);
  localparam logic [CNT_W-1:0] SNS_N = CNT_W'(SENSE_CYCLES);
  localparam logic [CNT_W-1:0] PRE_N = CNT_W'(PRESET_CYCLES);

  // True on the cycle whose step brings the phase counter to its end count
  function automatic logic cnt_hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
    logic [CNT_W:0] nxt;
    nxt = {1'b0, cnt} + 1'b1;
    cnt_hit = nxt >= {1'b0, lim};
  endfunction : cnt_hit

  typedef struct packed {
    csr_ctrl_s s1;
    csr_ctrl_s s2;
    logic [AW-1:0] a1;
    logic [AW-1:0] a2;
    logic [DW-1:0] d1;
    logic [DW-1:0] d2;
    csr_phase_e phase;
    logic [CNT_W-1:0] cnt;
    logic [AW-1:0] addr;
    logic sel;
    logic decoded;
    logic avail;
    logic [DW-1:0] dout;
    logic done;
  } csr_state_s;

  csr_state_s st_q;
  csr_state_s st_d;
  logic [DW-1:0] mem [ROW_COUNT][COLS];
  logic [ROW_BITS-1:0] row_idx;
  logic [COL_W-1:0] col_idx;
  logic strobe;
  logic writing;
  logic [DW-1:0] sensed;

  assign strobe = st_q.s2.cycle_strobe;
  assign row_idx = st_q.addr[ROW_BITS-1:0];
  assign col_idx = st_q.addr[AW-1:ROW_BITS];
  // Write allowed on selected chip, strobe high, write strobe low, address decoded
  assign writing = strobe && st_q.sel && !st_q.s2.write_strobe_n
                   && st_q.decoded;
  // Writing data drives the sense stage
  assign sensed = writing ? st_q.d2 : mem[row_idx][col_idx];

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = ctrl_in;
    st_d.s2 = st_q.s1;
    st_d.a1 = addr_in;
    st_d.a2 = st_q.a1;
    st_d.d1 = data_in;
    st_d.d2 = st_q.d1;
    unique case (st_q.phase)
      CSR_PRESET:
      begin
        if (!strobe)
        begin
          st_d.phase = CSR_IDLE;
        end
      end
      CSR_IDLE:
      begin
        if (strobe)
        begin
          st_d.addr = st_q.a2;
          st_d.sel = !st_q.s2.select_n;
          st_d.avail = 1'b0;
          st_d.dout = '0;
          st_d.cnt = '0;
          st_d.phase = CSR_OPEN;
        end
      end
      CSR_OPEN:
      begin
        st_d.phase = CSR_DECODE;
        st_d.cnt = '0;
      end
      CSR_DECODE:
      begin
        st_d.cnt = st_q.cnt + 1'b1;
        if (cnt_hit(st_q.cnt, DEC_N))
        begin
          st_d.decoded = 1'b1;
          st_d.cnt = '0;
          st_d.phase = CSR_ACTIVE;
        end
      end
      CSR_ACTIVE:
      begin
        if (!strobe)
        begin
          st_d.dout = st_q.dout;
          st_d.decoded = 1'b0;
          st_d.cnt = '0;
          st_d.phase = CSR_PRESETTING;
        end
        else if (!st_q.avail)
        begin
          st_d.cnt = st_q.cnt + 1'b1;
          if (cnt_hit(st_q.cnt, SNS_N))
          begin
            st_d.avail = 1'b1;
            st_d.done = 1'b1;
            st_d.dout = sensed;
          end
        end
        else
        begin
          st_d.dout = sensed;
        end
      end
      CSR_PRESETTING:
      begin
        st_d.cnt = st_q.cnt + 1'b1;
        if (cnt_hit(st_q.cnt, PRE_N))
        begin
          st_d.done = 1'b0;
          st_d.phase = CSR_IDLE;
        end
      end
      default:
      begin
        st_d.phase = CSR_PRESET;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Data sampled before termination; zero hold
  always_ff @(posedge clk)
  begin
    if (writing)
    begin
      mem[row_idx][col_idx] <= st_q.d2;
    end
  end

  always_comb
  begin
    row_select = '0;
    if (st_q.decoded && strobe)
    begin
      row_select[row_idx] = 1'b1;
    end
  end

  // Gate and kill act directly on the buffer, write strobe does not
  assign data_oe_n = !(st_q.sel && st_q.avail && ctrl_in.output_gate_high
                       && !ctrl_in.output_kill);
  assign data_out = st_q.dout;
  assign access_done_flag = st_q.done;
  assign phases.latch_open_phase = !(st_q.phase inside {CSR_OPEN, CSR_DECODE});
  assign phases.decode_release_phase = !(st_q.phase inside {CSR_DECODE, CSR_ACTIVE});
  assign phases.latch_close_phase = st_q.decoded;
  // Rails low in preset; one rises once decoded
  // Gated by the strobe so both rails drop as soon as the fall is seen
  assign addr_bit5_rails = (st_q.decoded && strobe)
                                        ? {st_q.addr[ROW_RAIL_BIT], !st_q.addr[ROW_RAIL_BIT]}
                                        : 2'h0;

  chk_rows_onehot: assert property (@(posedge clk) disable iff (rst)
    st_q.decoded && strobe |-> $onehot(row_select))
    else $error("row select not one-hot");
  chk_rows_preset: assert property (@(posedge clk) disable iff (rst)
    !strobe |-> row_select == '0 && addr_bit5_rails == 2'h0)
    else $error("decoders not preset");
  chk_buf_gate: assert property (@(posedge clk) disable iff (rst)
    (!ctrl_in.output_gate_high || ctrl_in.output_kill) |-> data_oe_n)
    else $error("buffer on while gated");
  chk_rise_clears: assert property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_IDLE && strobe |=> data_oe_n && data_out == '0)
    else $error("rise did not clear output");
  chk_hold_low: assert property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_PRESETTING |-> $stable(data_out))
    else $error("output changed in preset");
  chk_no_write_low: assert property (@(posedge clk) disable iff (rst)
    !strobe |-> !writing)
    else $error("write while strobe low");
  chk_done_falls: assert property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_ACTIVE && !strobe |-> ##[1:3] !access_done_flag)
    else $error("done flag did not fall");
  chk_write_echo: assert property (@(posedge clk) disable iff (rst)
    writing && st_q.avail |=> data_out == $past(st_q.d2))
    else $error("output not write data");
  chk_release_order: assert property (@(posedge clk) disable iff (rst)
    !phases.decode_release_phase |-> !phases.latch_open_phase || st_q.phase == CSR_ACTIVE)
    else $error("release before open");
  cov_read: cover property (@(posedge clk) disable iff (rst)
    st_q.sel && st_q.avail && !data_oe_n);
  cov_write: cover property (@(posedge clk) disable iff (rst) writing);
  cov_preset: cover property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_PRESETTING ##1 st_q.phase == CSR_IDLE);

  // Address latch and decoder checks
  chk_addr_held: assert property (@(posedge clk) disable iff (rst)
    st_q.phase inside {CSR_DECODE, CSR_ACTIVE, CSR_PRESETTING} |-> $stable(st_q.addr) && $stable(st_q.sel))
    else $error("latched address or select moved");
  chk_write_deferred: assert property (@(posedge clk) disable iff (rst)
    st_q.phase inside {CSR_OPEN, CSR_DECODE} |-> !writing)
    else $error("cell written before decode");
  chk_open_first: assert property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_OPEN |-> !phases.latch_open_phase && phases.decode_release_phase)
    else $error("open phase not first");
  chk_rails_close: assert property (@(posedge clk) disable iff (rst)
    addr_bit5_rails != 2'h0 |-> phases.latch_close_phase)
    else $error("rail up with latch window open");
  chk_rails_onehot: assert property (@(posedge clk) disable iff (rst)
    st_q.decoded && strobe |-> $onehot(addr_bit5_rails))
    else $error("bit 5 rails not one-hot");

  // Output buffer checks
  chk_oe_needs_data: assert property (@(posedge clk) disable iff (rst)
    !data_oe_n |-> st_q.sel && st_q.avail)
    else $error("buffer on without select or data");
  chk_kill_off: assert property (@(posedge clk) disable iff (rst)
    ctrl_in.output_kill |-> data_oe_n)
    else $error("buffer on while killed");
  chk_hold_idle: assert property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_IDLE && !strobe |=> $stable(data_out))
    else $error("output changed while strobe low");

  // Cycle sequencing checks
  chk_done_valid: assert property (@(posedge clk) disable iff (rst)
    $rose(access_done_flag) |-> st_q.avail && st_q.phase == CSR_ACTIVE)
    else $error("done flag without data");
  chk_open_clear: assert property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_OPEN |-> !st_q.avail && !access_done_flag)
    else $error("new cycle not cleared");
  chk_no_early_cycle: assert property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_PRESETTING |=> st_q.phase != CSR_OPEN)
    else $error("cycle started during preset");

  // Scenario coverage
  cov_deselect: cover property (@(posedge clk) disable iff (rst)
    st_q.phase == CSR_ACTIVE && !st_q.sel);
  cov_gate_off: cover property (@(posedge clk) disable iff (rst)
    st_q.sel && st_q.avail && data_oe_n);
endmodule : csram_core

// ===== inc/csram_pkg.sv
package csram_pkg;
  // Geometry: ten-bit address with four-bit words, or twelve-bit with one-bit words
  localparam int ADDR_W_WIDE = 10;
  localparam int DATA_W_WIDE = 4;
  localparam int ADDR_W_DEEP = 12;
  localparam int DATA_W_DEEP = 1;
  localparam int ROW_BITS = 6;
  localparam int ROW_COUNT = 64;
  localparam int ROW_RAIL_BIT = 5;
  // Internal timing in clk cycles after the strobe edge
  localparam int DECODE_CYCLES = 2;
  localparam int SENSE_CYCLES = 2;
  localparam int PRESET_CYCLES = 2;

  typedef enum logic [2:0] {
    CSR_PRESET,
    CSR_IDLE,
    CSR_OPEN,
    CSR_DECODE,
    CSR_ACTIVE,
    CSR_PRESETTING
  } csr_phase_e;

  typedef struct packed {
    logic cycle_strobe;
    logic select_n;
    logic write_strobe_n;
    logic output_gate_high;
    logic output_kill;
  } csr_ctrl_s;

  typedef struct packed {
    logic latch_open_phase;
    logic decode_release_phase;
    logic latch_close_phase;
  } csr_phases_s;
endpackage : csram_pkg

// ===== test/csram_ctl_model.sv
`timescale 1ns/1ps
module csram_ctl_model
  import csram_pkg::*;
#(
  parameter int AW = 10,
  parameter int DW = 4
) (
  input wire logic clk, // System clock
  input wire logic rst, // Reset, active high
  input wire logic go, // Start one cycle
  input wire logic wr, // Cycle is a write
  input wire logic sel_n, // Select for the cycle, low selects
  input wire logic [AW-1:0] a, // Cycle address
  input wire logic [DW-1:0] d, // Cycle write data
  input wire logic done_flag, // Access complete status
  output logic strobe_q, // Cycle strobe
  output logic sel_q, // Select pin
  output logic wr_n_q, // Write strobe pin
  output logic [AW-1:0] addr_q, // Address pins
  output logic [DW-1:0] data_q, // Data input pins
  output logic busy_q // Cycle in progress
);
  logic [1:0] st_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= 2'h0;
      strobe_q <= 1'b0;
      busy_q <= 1'b0;
      wr_n_q <= 1'b1;
      sel_q <= 1'b1;
      addr_q <= '0;
      data_q <= '0;
    end
    else
    begin
      if (st_q != 2'h1)
      begin
        wr_n_q <= ~wr_n_q; // Junk while strobe low
        sel_q <= ~sel_q;
        addr_q <= ~addr_q;
      end
      case (st_q)
        2'h0:
          if (go)
          begin
            st_q <= 2'h1;
            strobe_q <= 1'b1; // Select and address with the rise
            busy_q <= 1'b1;
            wr_n_q <= ~wr; // Held for all of strobe high
            sel_q <= sel_n;
            addr_q <= a;
            data_q <= d; // Driven continuously
          end
        2'h1:
          if (done_flag)
          begin
            st_q <= 2'h2;
            strobe_q <= 1'b0;
          end
        default:
          if (!done_flag)
          begin
            st_q <= 2'h0; // Next cycle only after preset
            busy_q <= 1'b0;
          end
      endcase
    end
  end
endmodule : csram_ctl_model

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import csram_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic go = 1'b0, wr = 1'b0, sel_n = 1'b0, gate = 1'b1, kill = 1'b0;
  logic [9:0] ta = '0, addr;
  logic [3:0] td = '0, din, data_out;
  logic strobe, sn, wn, busy, data_oe_n, access_done_flag;
  logic [1:0] addr_bit5_rails;
  logic [63:0] row_select;
  csr_phases_s phases;
  csr_ctrl_s ctrl;
  int n_mismatch = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  assign ctrl = '{strobe, sn, wn, gate, kill};
  csram_ctl_model i_ctl (.clk(clk), .rst(rst), .go(go), .wr(wr), .sel_n(sel_n), .a(ta),
    .d(td), .done_flag(access_done_flag), .strobe_q(strobe), .sel_q(sn), .wr_n_q(wn),
    .addr_q(addr), .data_q(din), .busy_q(busy));
  csram_core i_dut (.clk(clk), .rst(rst), .ctrl_in(ctrl), .addr_in(addr), .data_in(din),
    .data_out(data_out), .data_oe_n(data_oe_n), .access_done_flag(access_done_flag),
    .phases(phases), .addr_bit5_rails(addr_bit5_rails), .row_select(row_select));
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // Flags: write, deselect, gate, kill, expected enable_n, data checked
  task automatic cyc(input logic [5:0] f, input logic [9:0] a, input logic [3:0] d, ed);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    wr <= f[5];
    sel_n <= f[4];
    gate <= f[3];
    kill <= f[2];
    ta <= a;
    td <= d;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check(data_oe_n === 1'b1 && (data_out === 4'h0 || !f[0]), "not cleared");
    while (access_done_flag !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(data_out === ed || !f[0], "data at done");
    check(data_oe_n === f[1], "enable at done");
    check(row_select === 64'h1 << a[5:0], "row decode");
    check(addr_bit5_rails === {a[5], ~a[5]}, "bit 5 rails");
    if (!f[4] && f[1])
    begin
      @(posedge clk);
      gate <= 1'b1;
      kill <= 1'b0;
      #1 check(data_oe_n === 1'b0, "gate not immediate");
    end
    n = 0;
    while (busy !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(access_done_flag === 1'b0, "preset not done");
    check(data_out === ed || !f[0], "data not held");
  endtask : cyc
  initial
  begin
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    cyc(6'h29, 10'h000, 4'h5, 4'h5);
    cyc(6'h29, 10'h3ff, 4'ha, 4'ha);
    cyc(6'h23, 10'h02a, 4'h3, 4'h3);
    cyc(6'h3a, 10'h000, 4'hf, 4'h0);
    cyc(6'h09, 10'h000, 4'h0, 4'h5);
    cyc(6'h0f, 10'h3ff, 4'h0, 4'ha);
    cyc(6'h09, 10'h02a, 4'hc, 4'h3);
    cyc(6'h1a, 10'h02a, 4'h0, 4'h0);
    tally_and_finish();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : testbench
